// *** src/dual_async_serial_port.sv ***
// Purpose: Two full-duplex asynchronous serial ports with their baud timers.
// Assumes: clk_sys_i is the system clock; pins are synchronous to it.
// Notes: Registers are reached over a plain strobe port, read data one cycle later.
// Operation
// - One interrupt per port on tx/rx done
// - Port enables gated by global enable; port 1 uses the global bit 7 as its own enable
// - Priority bit raises port to high level
// - Vectors 23h/prio 5 and 3Bh/prio 7
// - Mode 1 frame: start, 8 LSB-first, stop
// - Mode 1 stores stop bit as ninth
// - Timer 1 overflow halved unless doubler set
// - Doublers at power and extended control bit7
// - Timer 1 reload period, 12 or 4 clocks
// - Timer 2 clk/2 baud source, port 0 only
// - System clock is the baud reference clock
// - Mode 1 transmit starts at next rollover
// - Mode 1 done flag two clocks after stop
// - Sixteen samples per bit, edge resets divider
// - Majority of three; bad start abandons frame
// - Mode 1 stop check gates buffer load and flag only when SC_MP is set
// - Receiver idles after mid stop bit
// - Modes 2/3 frame carries programmable ninth bit
// - Mode 2 baud clk/64 or clk/32
// - Mode 2 done flag as stop appears
// - Mode 3: mode 2 frame, timer baud
// - Mode field 01, 10, 11 decoding
// - Multiprocessor drops frames with ninth bit 0
//
// Implementation choices: the address-and-strobe port and the register addresses.
module dual_async_serial_port #(
  parameter int TX_DONE_DELAY = uart_pkg::TX_DONE_DELAY_CLK
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [uart_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [uart_pkg::REG_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [uart_pkg::REG_DW-1:0] reg_rdata_o,
  input wire logic rx_pin_p0_i,
  input wire logic rx_pin_p1_i,
  output logic tx_pin_p0_o,
  output logic tx_pin_p1_o,
  output logic irq_p0_o,
  output logic irq_p1_o,
  output logic irq_high_p0_o,
  output logic irq_high_p1_o,
  output logic [7:0] irq_vector_p0_o,
  output logic [7:0] irq_vector_p1_o,
  output logic [2:0] irq_nat_prio_p0_o,
  output logic [2:0] irq_nat_prio_p1_o
);
  import uart_pkg::*;

  if (TX_DONE_DELAY < 1 || TX_DONE_DELAY > 15) begin : g_bad_delay
    $error("TX_DONE_DELAY must lie between 1 and 15");
  end

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  logic [7:0] pwr_q;
  logic [7:0] ext_q;
  logic [7:0] irq_en_q;
  logic [7:0] irq_prio_q;
  logic [7:0] t1_reload_q;
  logic [15:0] t2_reload_q;
  logic [3:0] baud_q;
  logic [3:0] t1_pre_q;
  logic [7:0] t1_cnt_q;
  logic t2_pre_q;
  logic [15:0] t2_cnt_q;
  logic [7:0] rdata_q;
  logic [7:0] ctrl_w [2];
  logic [7:0] rxbuf_w [2];
  logic [1:0] txd_w;
  logic [1:0] rx_pin_w;
  logic t1_step;
  logic t1_ovf;
  logic t2_ovf;

  assign rx_pin_w = {rx_pin_p1_i, rx_pin_p0_i};

  // Shared control registers written from the register port.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_q <= 8'h00;
      ext_q <= 8'h00;
      irq_en_q <= 8'h00;
      irq_prio_q <= 8'h00;
      t1_reload_q <= 8'h00;
      t2_reload_q <= 16'h0000;
      baud_q <= 4'h0;
    end else if (reg_we_i) begin
      unique case (reg_addr_i)
        ADDR_PWR_CTRL: pwr_q <= reg_wdata_i;
        ADDR_EXT_IRQ_CTRL: ext_q <= reg_wdata_i;
        ADDR_IRQ_EN: irq_en_q <= reg_wdata_i;
        ADDR_IRQ_PRIO: irq_prio_q <= reg_wdata_i;
        ADDR_T1_RELOAD: t1_reload_q <= reg_wdata_i;
        ADDR_T2_RELOAD_HI: t2_reload_q[15:8] <= reg_wdata_i;
        ADDR_T2_RELOAD_LO: t2_reload_q[7:0] <= reg_wdata_i;
        ADDR_BAUD_CTRL: baud_q <= reg_wdata_i[3:0];
        default: ;
      endcase
    end
  end

  // Timer 1: 8-bit auto-reload, one increment per 12 or 4 system clocks.
  assign t1_step = baud_q[BC_T1_RUN] &&
      (t1_pre_q == (baud_q[BC_T1_FAST] ? T1_FAST_DIV : T1_STD_DIV) - 4'h1);
  assign t1_ovf = t1_step && (t1_cnt_q == T1_MAX);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      t1_pre_q <= 4'h0;
      t1_cnt_q <= 8'h00;
    end else if (!baud_q[BC_T1_RUN]) begin
      t1_pre_q <= 4'h0;
    end else begin
      t1_pre_q <= t1_step ? 4'h0 : t1_pre_q + 4'h1;
      if (t1_ovf) begin
        t1_cnt_q <= t1_reload_q;
      end else if (t1_step) begin
        t1_cnt_q <= t1_cnt_q + 8'h01;
      end
    end
  end

  // Timer 2: 16-bit auto-reload counting at half the system clock.
  assign t2_ovf = baud_q[BC_T2_RUN] && t2_pre_q && (t2_cnt_q == T2_MAX);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      t2_pre_q <= 1'b0;
      t2_cnt_q <= 16'h0000;
    end else if (baud_q[BC_T2_RUN]) begin
      t2_pre_q <= !t2_pre_q;
      if (t2_ovf) begin
        t2_cnt_q <= t2_reload_q;
      end else if (t2_pre_q) begin
        t2_cnt_q <= t2_cnt_q + 16'h0001;
      end
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam logic [7:0] A_CTRL = (p == 0) ? ADDR_SER_CTRL_P0 : ADDR_SER_CTRL_P1;
    localparam logic [7:0] A_BUF = (p == 0) ? ADDR_SER_BUF_P0 : ADDR_SER_BUF_P1;
    logic [7:0] ctrl_q;
    logic [7:0] rxbuf_q;
    logic [1:0] mode;
    logic mode1;
    logic active;
    logic doubler;
    logic half_q;
    logic [1:0] m2_cnt_q;
    logic m2_tick;
    logic timer_tick;
    logic tick;
    tx_state_t tx_state_q;
    logic [3:0] tx_div_q;
    logic tx_roll;
    logic [10:0] frame_q;
    logic [3:0] left_q;
    logic [3:0] dly_q;
    logic txd_q;
    logic tx_done_set;
    logic tx_load;
    rx_state_t rx_state_q;
    logic [3:0] rx_div_q;
    logic [3:0] rx_bit_q;
    logic [1:0] samp_q;
    logic [8:0] rx_sh_q;
    logic rx_prev_q;
    logic vote;
    logic check_bit;
    logic rx_stop_now;
    logic rx_accept;

    assign mode = ctrl_q[SC_MODE_HI:SC_MODE_LO];
    assign mode1 = (mode == MODE_1);
    assign active = (mode == MODE_1) || (mode == MODE_2) || (mode == MODE_3);
    assign doubler = (p == 0) ? pwr_q[DOUBLER_BIT] : ext_q[DOUBLER_BIT];

    // Oversampling tick: timer overflow in modes 1 and 3, fixed rate in mode 2.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        half_q <= 1'b0;
      end else if (t1_ovf) begin
        half_q <= !half_q;
      end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        m2_cnt_q <= 2'h0;
      end else begin
        m2_cnt_q <= m2_tick ? 2'h0 : m2_cnt_q + 2'h1;
      end
    end

    assign m2_tick = m2_cnt_q == ((doubler ? M2_DIV_FAST : M2_DIV_SLOW) - 2'h1);
    assign timer_tick = ((p == 0) && baud_q[BC_P0_T2]) ? t2_ovf
        : (t1_ovf && (doubler || half_q));
    assign tick = (mode == MODE_2) ? m2_tick : (active && timer_tick);

    // Transmitter; modes 2 and 3 flag done as the stop bit reaches the pin.
    assign tx_roll = tick && (tx_div_q == OVS_LAST);
    assign tx_load = reg_we_i && (reg_addr_i == A_BUF) && active &&
        (tx_state_q == TX_IDLE);
    assign tx_done_set = (tx_state_q == TX_SHIFT && tx_roll && left_q == 4'h2 && !mode1)
        || (tx_state_q == TX_DONE_WAIT && dly_q == 4'(TX_DONE_DELAY - 1));

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        tx_div_q <= 4'h0;
      end else if (tick) begin
        tx_div_q <= tx_div_q + 4'h1;
      end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        tx_state_q <= TX_IDLE;
        frame_q <= '1;
        left_q <= 4'h0;
        dly_q <= 4'h0;
        txd_q <= 1'b1;
      end else begin
        unique case (tx_state_q)
          TX_IDLE: begin
            if (tx_load) begin
              frame_q <= {1'b1, mode1 | ctrl_q[SC_TX_NINTH], reg_wdata_i, 1'b0};
              left_q <= mode1 ? FRAME_BITS_M1 : FRAME_BITS_M2;
              tx_state_q <= TX_WAIT;
            end
          end
          TX_WAIT: begin
            if (tx_roll) begin
              txd_q <= frame_q[0];
              frame_q <= {1'b1, frame_q[10:1]};
              tx_state_q <= TX_SHIFT;
            end
          end
          TX_SHIFT: begin
            if (tx_roll) begin
              if (left_q == 4'h1) begin
                dly_q <= 4'h0;
                tx_state_q <= mode1 ? TX_DONE_WAIT : TX_IDLE;
              end else begin
                txd_q <= frame_q[0];
                frame_q <= {1'b1, frame_q[10:1]};
              end
              left_q <= left_q - 4'h1;
            end
          end
          TX_DONE_WAIT: begin
            dly_q <= dly_q + 4'h1;
            if (tx_done_set) begin
              tx_state_q <= TX_IDLE;
            end
          end
        endcase
      end
    end

    // Receiver.
    assign vote = maj3(samp_q[0], samp_q[1], rx_pin_w[p]);
    assign check_bit = mode1 ? vote : rx_sh_q[8];
    assign rx_stop_now = (rx_state_q == RX_ACTIVE) && tick && (rx_div_q == SAMPLE_C) &&
        (rx_bit_q == (mode1 ? FRAME_BITS_M1 : FRAME_BITS_M2) - 4'h1);
    assign rx_accept = rx_stop_now && !ctrl_q[SC_RX_DONE] &&
        (!ctrl_q[SC_MP] || check_bit);

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        rx_prev_q <= 1'b1;
      end else if (tick) begin
        rx_prev_q <= rx_pin_w[p];
      end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        rx_state_q <= RX_IDLE;
        rx_div_q <= 4'h0;
        rx_bit_q <= 4'h0;
        samp_q <= 2'h3;
        rx_sh_q <= 9'h000;
      end else if (tick) begin
        unique case (rx_state_q)
          RX_IDLE: begin
            if (ctrl_q[SC_RX_EN] && rx_prev_q && !rx_pin_w[p]) begin
              rx_div_q <= 4'h1;
              rx_bit_q <= 4'h0;
              rx_state_q <= RX_ACTIVE;
            end
          end
          RX_ACTIVE: begin
            rx_div_q <= rx_div_q + 4'h1;
            if (rx_div_q == SAMPLE_A) begin
              samp_q[0] <= rx_pin_w[p];
            end
            if (rx_div_q == SAMPLE_B) begin
              samp_q[1] <= rx_pin_w[p];
            end
            if (rx_div_q == SAMPLE_C) begin
              if (rx_bit_q == 4'h0 && vote) begin
                rx_state_q <= RX_IDLE;
              end else if (rx_stop_now) begin
                rx_state_q <= RX_IDLE;
              end else begin
                if (rx_bit_q != 4'h0) begin
                  rx_sh_q <= {vote, rx_sh_q[8:1]};
                end
                rx_bit_q <= rx_bit_q + 4'h1;
              end
            end
          end
        endcase
      end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        rxbuf_q <= 8'h00;
      end else if (rx_accept) begin
        rxbuf_q <= mode1 ? rx_sh_q[8:1] : rx_sh_q[7:0];
      end
    end

    // Control register; hardware sets win over a software clear.
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ctrl_q <= 8'h00;
      end else begin
        if (reg_we_i && reg_addr_i == A_CTRL) begin
          ctrl_q <= reg_wdata_i;
        end
        if (rx_accept) begin
          ctrl_q[SC_RX_NINTH] <= check_bit;
          ctrl_q[SC_RX_DONE] <= 1'b1;
        end
        if (tx_done_set) begin
          ctrl_q[SC_TX_DONE] <= 1'b1;
        end
      end
    end

    assign ctrl_w[p] = ctrl_q;
    assign rxbuf_w[p] = rxbuf_q;
    assign txd_w[p] = txd_q;
  end

  // Read port: data stands only in the cycle after the read strobe.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        ADDR_SER_CTRL_P0: rdata_q <= ctrl_w[0];
        ADDR_SER_BUF_P0: rdata_q <= rxbuf_w[0];
        ADDR_SER_CTRL_P1: rdata_q <= ctrl_w[1];
        ADDR_SER_BUF_P1: rdata_q <= rxbuf_w[1];
        ADDR_PWR_CTRL: rdata_q <= pwr_q;
        ADDR_EXT_IRQ_CTRL: rdata_q <= ext_q;
        ADDR_IRQ_EN: rdata_q <= irq_en_q;
        ADDR_IRQ_PRIO: rdata_q <= irq_prio_q;
        ADDR_T1_RELOAD: rdata_q <= t1_reload_q;
        ADDR_T2_RELOAD_HI: rdata_q <= t2_reload_q[15:8];
        ADDR_T2_RELOAD_LO: rdata_q <= t2_reload_q[7:0];
        ADDR_BAUD_CTRL: rdata_q <= {4'h0, baud_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign tx_pin_p0_o = txd_w[0];
  assign tx_pin_p1_o = txd_w[1];

  // Interrupt requests and their fixed vector map.
  assign irq_p0_o = (ctrl_w[0][SC_TX_DONE] | ctrl_w[0][SC_RX_DONE]) &&
      irq_en_q[IRQEN_P0_BIT] && irq_en_q[IRQEN_GLOBAL_BIT];
  assign irq_p1_o = (ctrl_w[1][SC_TX_DONE] | ctrl_w[1][SC_RX_DONE]) &&
      irq_en_q[IRQEN_P1_BIT] && irq_en_q[IRQEN_GLOBAL_BIT];
  assign irq_high_p0_o = irq_prio_q[PRIO_P0_BIT];
  assign irq_high_p1_o = irq_prio_q[PRIO_P1_BIT];
  assign irq_vector_p0_o = VEC_P0;
  assign irq_vector_p1_o = VEC_P1;
  assign irq_nat_prio_p0_o = NAT_PRIO_P0;
  assign irq_nat_prio_p1_o = NAT_PRIO_P1;
endmodule

// *** src/uart_pkg.sv ***
// Purpose: Shared constants for the dual asynchronous serial port block.
// Assumes: 8-bit register port with byte-wide addresses.
// Notes: All offsets, field positions and timing counts live here.
package uart_pkg;
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  // Register byte addresses.
  localparam logic [7:0] ADDR_SER_CTRL_P0 = 8'h98;
  localparam logic [7:0] ADDR_SER_BUF_P0 = 8'h99;
  localparam logic [7:0] ADDR_SER_CTRL_P1 = 8'hC0;
  localparam logic [7:0] ADDR_SER_BUF_P1 = 8'hC1;
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h87;
  localparam logic [7:0] ADDR_EXT_IRQ_CTRL = 8'hD8;
  localparam logic [7:0] ADDR_IRQ_EN = 8'hA8;
  localparam logic [7:0] ADDR_IRQ_PRIO = 8'hB8;
  localparam logic [7:0] ADDR_T1_RELOAD = 8'h8D;
  localparam logic [7:0] ADDR_T2_RELOAD_HI = 8'hCA;
  localparam logic [7:0] ADDR_T2_RELOAD_LO = 8'hCB;
  localparam logic [7:0] ADDR_BAUD_CTRL = 8'hE4;
  // Serial control, doubler, interrupt enable and priority field positions.
  localparam int SC_MODE_HI = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_MP = 5;
  localparam int SC_RX_EN = 4;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_DONE = 0;
  localparam int DOUBLER_BIT = 7;
  localparam int IRQEN_P0_BIT = 3;
  localparam int IRQEN_P1_BIT = 7;
  localparam int IRQEN_GLOBAL_BIT = 7;
  localparam int PRIO_P0_BIT = 4;
  localparam int PRIO_P1_BIT = 6;
  // Baud control fields.
  localparam int BC_T1_RUN = 0;
  localparam int BC_T1_FAST = 1;
  localparam int BC_T2_RUN = 2;
  localparam int BC_P0_T2 = 3;
  // Mode field encodings.
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;
  // Timing.
  localparam logic [3:0] T1_STD_DIV = 4'hC;
  localparam logic [3:0] T1_FAST_DIV = 4'h4;
  localparam logic [1:0] M2_DIV_FAST = 2'h2;
  localparam logic [1:0] M2_DIV_SLOW = 2'h0;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  localparam logic [3:0] FRAME_BITS_M1 = 4'hA;
  localparam logic [3:0] FRAME_BITS_M2 = 4'hB;
  localparam int TX_DONE_DELAY_CLK = 2;
  localparam logic [7:0] T1_MAX = 8'hFF;
  localparam logic [15:0] T2_MAX = 16'hFFFF;
  // Interrupt vector map.
  localparam logic [7:0] VEC_P0 = 8'h23;
  localparam logic [7:0] VEC_P1 = 8'h3B;
  localparam logic [2:0] NAT_PRIO_P0 = 3'h5;
  localparam logic [2:0] NAT_PRIO_P1 = 3'h7;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT, TX_DONE_WAIT} tx_state_t;
  typedef enum logic {RX_IDLE, RX_ACTIVE} rx_state_t;
endpackage

// *** verif/dual_async_serial_port_tb.sv ***
// Purpose: Self-checking bench for the dual asynchronous serial port.
// Assumes: Mode 2 with doubler gives 32 clocks a bit; timer 1 fast reload FFh gives 64.
// Notes: Timer 2 is not exercised because its first overflow takes too long.
module dual_async_serial_port_tb;
  import uart_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] rdata;
  logic rx0, rx1, tx0, tx1, irq0, irq1, hi0, hi1;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  dual_async_serial_port u_dual_async_serial_port (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re), .reg_rdata_o(rdata),
    .rx_pin_p0_i(rx0), .rx_pin_p1_i(rx1), .tx_pin_p0_o(tx0), .tx_pin_p1_o(tx1),
    .irq_p0_o(irq0), .irq_p1_o(irq1), .irq_high_p0_o(hi0), .irq_high_p1_o(hi1),
    .irq_vector_p0_o(), .irq_vector_p1_o(), .irq_nat_prio_p0_o(), .irq_nat_prio_p1_o());
  remote_station u_remote_station_p0 (.clk_i(clk_sys_i), .line_i(tx0), .line_o(rx0));
  remote_station u_remote_station_p1 (.clk_i(clk_sys_i), .line_i(tx1), .line_o(rx1));
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys_i);
    reg_we <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys_i);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys_i);
    reg_re <= 1'b0;
    #1 chk(what, 10'(exp), 10'(rdata));
  endtask
  task automatic t_reset();
    rdchk(ADDR_SER_CTRL_P0, 8'h00, "ctrl0 reset");
    rdchk(8'h00, 8'h00, "unmapped read");
    chk("tx pins idle", 10'h3, {8'h00, tx1, tx0});
  endtask
  task automatic t_m2_tx();
    logic [9:0] sh;
    bit ok;
    wr(ADDR_PWR_CTRL, 8'h80);
    wr(ADDR_SER_CTRL_P0, 8'h88);
    fork
      u_remote_station_p0.grab(11, 32, 400, sh, ok);
      begin
        wr(ADDR_SER_BUF_P0, 8'hA5);
        wr(ADDR_SER_BUF_P0, 8'h3C);
      end
    join
    chk("m2 frame", 10'h3A5, sh);
    rdchk(ADDR_SER_CTRL_P0, 8'h8A, "m2 tx done");
    u_remote_station_p0.grab(11, 32, 400, sh, ok);
    chk("busy write dropped", 10'h0, 10'(ok));
    wr(ADDR_IRQ_EN, 8'h88);
    #1 chk("irq0 on", 10'h1, 10'(irq0));
    wr(ADDR_IRQ_PRIO, 8'h10);
    #1 chk("irq0 high", 10'h1, 10'(hi0));
    wr(ADDR_IRQ_EN, 8'h08);
    #1 chk("irq0 global off", 10'h0, 10'(irq0));
    wr(ADDR_IRQ_EN, 8'h88);
    wr(ADDR_SER_CTRL_P0, 8'h88);
    #1 chk("irq0 cleared", 10'h0, 10'(irq0));
  endtask
  task automatic t_m2_rx();
    wr(ADDR_SER_CTRL_P0, 8'hB0);
    u_remote_station_p0.send(8'h11, 1'b0, 11, 32);
    rdchk(ADDR_SER_CTRL_P0, 8'hB0, "mp ninth zero");
    u_remote_station_p0.send(8'h5A, 1'b1, 11, 32);
    rdchk(ADDR_SER_CTRL_P0, 8'hB5, "mp ninth one");
    rdchk(ADDR_SER_BUF_P0, 8'h5A, "m2 rx data");
    u_remote_station_p0.send(8'h77, 1'b1, 11, 32);
    rdchk(ADDR_SER_BUF_P0, 8'h5A, "done still set");
    wr(ADDR_SER_CTRL_P0, 8'hB0);
    u_remote_station_p0.glitch(4);
    repeat (400) @(posedge clk_sys_i);
    rdchk(ADDR_SER_CTRL_P0, 8'hB0, "short start");
    u_remote_station_p0.send(8'hC6, 1'b1, 11, 32);
    rdchk(ADDR_SER_BUF_P0, 8'hC6, "rearm");
  endtask
  task automatic t_m1_p1();
    logic [9:0] sh;
    bit ok;
    wr(ADDR_BAUD_CTRL, 8'h03);
    wr(ADDR_T1_RELOAD, 8'hFF);
    wr(ADDR_EXT_IRQ_CTRL, 8'h80);
    wr(ADDR_SER_CTRL_P1, 8'h50);
    fork
      u_remote_station_p1.grab(10, 64, 2000, sh, ok);
      wr(ADDR_SER_BUF_P1, 8'hC3);
    join
    chk("m1 frame", 10'h1C3, sh);
    repeat (40) @(posedge clk_sys_i);
    rdchk(ADDR_SER_CTRL_P1, 8'h52, "m1 tx done");
    wr(ADDR_SER_CTRL_P1, 8'h50);
    u_remote_station_p1.send(8'h96, 1'b0, 10, 64);
    rdchk(ADDR_SER_CTRL_P1, 8'h55, "m1 rx stop");
    rdchk(ADDR_SER_BUF_P1, 8'h96, "m1 rx data");
    wr(ADDR_IRQ_EN, 8'h80);
    #1 chk("irq1 only", 10'h2, {8'h00, irq1, irq0});
  endtask
  task automatic t_m3_p0();
    logic [9:0] sh;
    bit ok;
    wr(ADDR_SER_CTRL_P0, 8'hC8);
    fork
      u_remote_station_p0.grab(11, 64, 2000, sh, ok);
      wr(ADDR_SER_BUF_P0, 8'h3C);
    join
    chk("m3 frame", 10'h33C, sh);
    // Let the stop bit finish, then run mode 2 without the doubler: 64 clocks a bit.
    repeat (40) @(posedge clk_sys_i);
    wr(ADDR_PWR_CTRL, 8'h00);
    wr(ADDR_SER_CTRL_P0, 8'h88);
    fork
      u_remote_station_p0.grab(11, 64, 2000, sh, ok);
      wr(ADDR_SER_BUF_P0, 8'h5A);
    join
    chk("m2 slow frame", 10'h35A, sh);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_m2_tx();
    t_m2_rx();
    t_m1_p1();
    t_m3_p0();
    test_done();
  end
endmodule

// *** verif/remote_station.sv ***
// Purpose: Remote asynchronous serial station facing one port.
// Assumes: Bit time given in system clocks per call.
// Notes: Line idles high between frames; sampling on the falling clock edge.
module remote_station (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line_o = 1'b1;
  task automatic send(input logic [7:0] d, input logic ninth, input int nbits, input int bclk);
    logic [10:0] f;
    f = (nbits == 11) ? {1'b1, ninth, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (bclk - 1) @(posedge clk_i);
    end
  endtask
  task automatic glitch(input int n);
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    line_o <= 1'b1;
  endtask
  task automatic grab(input int nbits, input int bclk, input int lim,
                      output logic [9:0] sh, output bit ok);
    sh = '0;
    ok = 1'b0;
    for (int i = 0; i < lim && line_i; i++) @(negedge clk_i);
    if (line_i) return;
    ok = 1'b1;
    repeat (bclk / 2) @(negedge clk_i);
    for (int j = 0; j < nbits - 1; j++) begin
      repeat (bclk) @(negedge clk_i);
      sh[j] = line_i;
    end
  endtask
endmodule

// *** verif/serial_port_checker_sva.sv ***
// Purpose: Port-level checks for the dual asynchronous serial port.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Helper flops mirror the interrupt enable byte and buffer-write history.
module serial_port_checker
  import uart_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic tx_pin_p0_o,
  input wire logic irq_p0_o,
  input wire logic irq_p1_o,
  input wire logic irq_high_p0_o,
  input wire logic irq_high_p1_o,
  input wire logic [7:0] irq_vector_p0_o,
  input wire logic [7:0] irq_vector_p1_o,
  input wire logic [2:0] irq_nat_prio_p0_o,
  input wire logic [2:0] irq_nat_prio_p1_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] en_q;
  logic wrote_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_q <= 8'h00;
    end else if (reg_we_i && reg_addr_i == ADDR_IRQ_EN) begin
      en_q <= reg_wdata_i;
    end
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wrote_q <= 1'b0;
    end else if (reg_we_i && reg_addr_i == ADDR_SER_BUF_P0) begin
      wrote_q <= 1'b1;
    end
  end
  property p_vec_p0;
    irq_vector_p0_o == 8'h23 && irq_nat_prio_p0_o == 3'h5;
  endproperty
  a_vec_p0: assert property (p_vec_p0) else $error("port 0 vector wrong");
  property p_vec_p1;
    irq_vector_p1_o == 8'h3B && irq_nat_prio_p1_o == 3'h7;
  endproperty
  a_vec_p1: assert property (p_vec_p1) else $error("port 1 vector wrong");
  property p_rdata_idle;
    !reg_re_i |=> reg_rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_prio_p0;
    reg_we_i && reg_addr_i == ADDR_IRQ_PRIO |=> irq_high_p0_o == $past(reg_wdata_i[4]);
  endproperty
  a_prio_p0: assert property (p_prio_p0) else $error("port 0 priority wrong");
  property p_prio_p1;
    reg_we_i && reg_addr_i == ADDR_IRQ_PRIO |=> irq_high_p1_o == $past(reg_wdata_i[6]);
  endproperty
  a_prio_p1: assert property (p_prio_p1) else $error("port 1 priority wrong");
  property p_gate_p0;
    irq_p0_o |-> en_q[3] && en_q[7];
  endproperty
  a_gate_p0: assert property (p_gate_p0) else $error("port 0 irq not gated");
  property p_gate_p1;
    irq_p1_o |-> en_q[7];
  endproperty
  a_gate_p1: assert property (p_gate_p1) else $error("port 1 irq not gated");
  property p_tx_start;
    $fell(tx_pin_p0_o) |-> wrote_q;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx started unloaded");
endmodule
bind dual_async_serial_port serial_port_checker u_serial_port_checker (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .tx_pin_p0_o(tx_pin_p0_o), .irq_p0_o(irq_p0_o),
  .irq_p1_o(irq_p1_o), .irq_high_p0_o(irq_high_p0_o), .irq_high_p1_o(irq_high_p1_o),
  .irq_vector_p0_o(irq_vector_p0_o), .irq_vector_p1_o(irq_vector_p1_o),
  .irq_nat_prio_p0_o(irq_nat_prio_p0_o), .irq_nat_prio_p1_o(irq_nat_prio_p1_o));
